// *** hw/dosm_map.vh ***
// Purpose: constants for the drive operating state sequencer
// Assumes: 50 MHz reference clock
// Notes:   state codes are one-hot, bit n-1 set for state n
`ifndef DOSM_MAP_VH
`define DOSM_MAP_VH

// ==========================================================
// state codes (one-hot, 8 states)
`define DOSM_ST_NOT_READY      8'h01
`define DOSM_ST_SW_DISABLED    8'h02
`define DOSM_ST_READY          8'h04
`define DOSM_ST_SWITCHED_ON    8'h08
`define DOSM_ST_OP_ENABLED     8'h10
`define DOSM_ST_QUICK_STOP     8'h20
`define DOSM_ST_FAULT_REACT    8'h40
`define DOSM_ST_FAULT          8'h80

// ==========================================================
// reported state numbers in the status word
`define DOSM_NUM_W             4
`define DOSM_NUM_SW_DISABLED   4'h2
`define DOSM_NUM_READY         4'h3
`define DOSM_NUM_SWITCHED_ON   4'h4
`define DOSM_NUM_OP_ENABLED    4'h5
`define DOSM_NUM_QUICK_STOP    4'h6
`define DOSM_NUM_FAULT_REACT   4'h7
`define DOSM_NUM_FAULT         4'h8

// ==========================================================
// command codes from the control word decoder
`define DOSM_CMD_W             3
`define DOSM_CMD_NONE          3'h0
`define DOSM_CMD_SHUTDOWN      3'h1
`define DOSM_CMD_SWITCH_ON     3'h2
`define DOSM_CMD_ENABLE_OP     3'h3
`define DOSM_CMD_DISABLE_OP    3'h4
`define DOSM_CMD_DISABLE_V     3'h5
`define DOSM_CMD_QUICK_STOP    3'h6
`define DOSM_CMD_FAULT_RESET   3'h7

// ==========================================================
// timing
`define DOSM_INIT_NS           200
`define DOSM_CLK_NS            20
`define DOSM_INIT_CYC          ((`DOSM_INIT_NS + `DOSM_CLK_NS - 1) / `DOSM_CLK_NS)
`define DOSM_CNT_W             8
`define DOSM_SYNC_RESET_VAL    2'h0

`endif

// *** hw/dosm_sync.v ***
// Purpose: two-flop synchroniser for a group of pin level inputs
// Assumes: inputs are levels, each bit crossed independently
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`include "dosm_map.vh"

module dosm_sync #(
   parameter W = 4
) (
   input  wire         i_ref_clk,
   input  wire         i_arst_n,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

   // ==========================================================
   // per-bit double flop
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg [1:0] stage;
         always @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               stage <= `DOSM_SYNC_RESET_VAL;
            end else begin
               stage <= {stage[0], i_async[g]};
            end
         end
         assign o_sync[g] = stage[1];
      end
   endgenerate

endmodule

// *** hw/dosm_top.v ***
// Purpose: operating state sequencer of a variable speed drive
// Assumes: decoded commands arrive as one-cycle pulses on i_ref_clk;
//          mains, halt and stop-done levels come from pins
// Notes:   the control word bit map is decoded outside this block
//
// Overview of operation
// R1 - state 1 is transient and never shown in the status word
// R2 - status word always reflects the current operating state
// R3 - state changes only on a command or an internal event
// R4 - state 2: power stage not ready, no motor supply, all params open
// R5 - state 3: motor off, wait for mains before entering state 4
// R6 - contactor open in states 2 and 3, closed in 4 and 5
// R7 - power stage supply required in 4 and 5, not in 2
// R8 - state 4: power stage on, no output voltage, adjust params open
// R9 - configuration change in state 4 returns to state 2
// R10 - state 5: stage enabled, motor supplied, config changes refused
// R11 - state 5 with zero reference or halt gives no torque, except while a ramped disable stop is in progress
// R12 - self-tuning starts only in state 5
// R13 - enable operation needs valid channel and a reference seen once; a reference is needed only if the channel carries one
// R14 - disable operation with select 0: straight to 4, coast
// R15 - disable operation with select 1: ramp stop, then state 4
// R16 - quick stop state 6 stays locked, restart only through state 2
// R17 - fault state 8: power stage off, no motor supply
// R18 - reset holds state 1, then advances to 2 on its own
// R19 - one distinct code per state drives status and enables
`timescale 1ns/1ps
`include "dosm_map.vh"

module dosm_top (
   input  wire                   i_ref_clk,
   input  wire                   i_arst_n,
   input  wire [`DOSM_CMD_W-1:0] i_cmd,
   input  wire                   i_cmd_valid,
   input  wire                   i_channel_valid,
   input  wire                   i_channel_has_ref,
   input  wire                   i_ref_received,
   input  wire                   i_ref_zero,
   input  wire                   i_disable_stop_select,
   input  wire                   i_contactor_variant,
   input  wire                   i_cfg_write,
   input  wire                   i_adj_write,
   input  wire                   i_tune_req,
   input  wire                   i_fault_detect,
   input  wire                   i_fault_react_done,
   input  wire                   i_mains_ok,
   input  wire                   i_halt,
   input  wire                   i_ramp_done,
   output reg  [`DOSM_NUM_W-1:0] o_state_status_word,
   output reg                    o_status_valid,
   output reg                    o_power_stage_ready,
   output reg                    o_power_stage_enable,
   output reg                    o_motor_supply,
   output reg                    o_torque_enable,
   output reg                    o_contactor_close,
   output reg                    o_supply_required,
   output reg                    o_ramp_stop,
   output reg                    o_coast_stop,
   output reg                    o_tune_start,
   output wire                   o_cfg_accept,
   output wire                   o_adj_accept
);

   // ==========================================================
   // one-hot state codes
   localparam [7:0] ST_NOT_READY   = `DOSM_ST_NOT_READY;
   localparam [7:0] ST_SW_DISABLED = `DOSM_ST_SW_DISABLED;
   localparam [7:0] ST_READY       = `DOSM_ST_READY;
   localparam [7:0] ST_SWITCHED_ON = `DOSM_ST_SWITCHED_ON;
   localparam [7:0] ST_OP_ENABLED  = `DOSM_ST_OP_ENABLED;
   localparam [7:0] ST_QUICK_STOP  = `DOSM_ST_QUICK_STOP;
   localparam [7:0] ST_FAULT_REACT = `DOSM_ST_FAULT_REACT;
   localparam [7:0] ST_FAULT       = `DOSM_ST_FAULT;
   // init count cut to the counter width on purpose
   localparam integer           INIT_CYC_I = `DOSM_INIT_CYC;
   localparam [`DOSM_CNT_W-1:0] INIT_CYC   = INIT_CYC_I[`DOSM_CNT_W-1:0];

   // ==========================================================
   // pin levels crossed into the clock domain
   wire [2:0] pin_sync;
   wire       mains_ok;
   wire       halt;
   wire       ramp_done;

   dosm_sync #(
      .W (3)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_async   ({i_ramp_done, i_halt, i_mains_ok}),
      .o_sync    (pin_sync)
   );

   assign mains_ok  = pin_sync[0];
   assign halt      = pin_sync[1];
   assign ramp_done = pin_sync[2];

   // ==========================================================
   // state register and helpers
   reg [7:0]             state;
   reg [7:0]             next_state;
   reg [`DOSM_CNT_W-1:0] init_cnt;
   reg                   ramping;
   reg                   next_ramping;

   // ramp in progress before leaving state 5 counts as state 5
   function is_state;
      input [7:0] cur;
      input [7:0] code;
      begin
         is_state = (cur == code);
      end
   endfunction

   function cmd_is;
      input                   vld;
      input [`DOSM_CMD_W-1:0] cmd;
      input [`DOSM_CMD_W-1:0] code;
      begin
         cmd_is = vld && (cmd == code);
      end
   endfunction

   wire c_shutdown = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_SHUTDOWN);
   wire c_switch_on = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_SWITCH_ON);
   wire c_enable = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_ENABLE_OP);
   wire c_disable = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_DISABLE_OP);
   wire c_dis_volt = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_DISABLE_V);
   wire c_qstop = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_QUICK_STOP);
   wire c_freset = cmd_is(i_cmd_valid, i_cmd, `DOSM_CMD_FAULT_RESET);

   // enable only from a valid channel; a shared reference channel
   // must have delivered one reference first
   wire enable_ok = c_enable && i_channel_valid &&
                    (!i_channel_has_ref || i_ref_received);   // [R13]

   wire init_done = (init_cnt == INIT_CYC);

   // ==========================================================
   // init counter
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         init_cnt <= {`DOSM_CNT_W{1'b0}};
      end else if (is_state(state, ST_NOT_READY) && !init_done) begin
         init_cnt <= init_cnt + 1'b1;
      end
   end

   // ==========================================================
   // transitions: commands or internal events only
   always @* begin
      next_state   = state;
      next_ramping = ramping;
      case (state)
         ST_NOT_READY: begin
            if (init_done) begin
               next_state = ST_SW_DISABLED;                   // [R18]
            end
         end
         ST_SW_DISABLED: begin
            if (c_shutdown) begin
               next_state = ST_READY;                         // [R3]
            end
         end
         ST_READY: begin
            if (c_dis_volt || c_qstop) begin
               next_state = ST_SW_DISABLED;
            end else if (c_switch_on && mains_ok) begin
               next_state = ST_SWITCHED_ON;                   // [R5]
            end
         end
         ST_SWITCHED_ON: begin
            if (i_cfg_write) begin
               next_state = ST_SW_DISABLED;                   // [R9]
            end else if (c_dis_volt || c_qstop) begin
               next_state = ST_SW_DISABLED;
            end else if (c_shutdown) begin
               next_state = ST_READY;
            end else if (enable_ok) begin
               next_state = ST_OP_ENABLED;                    // [R13]
            end
         end
         ST_OP_ENABLED: begin
            if (c_qstop) begin
               next_state   = ST_QUICK_STOP;
               next_ramping = 1'b0;
            end else if (c_dis_volt) begin
               next_state   = ST_SW_DISABLED;
               next_ramping = 1'b0;
            end else if (c_shutdown) begin
               next_state   = ST_READY;
               next_ramping = 1'b0;
            // quick stop, disable voltage and shutdown outrank a ramp in progress; a new disable is ignored
            end else if (ramping) begin
               if (ramp_done) begin
                  next_state   = ST_SWITCHED_ON;              // [R15]
                  next_ramping = 1'b0;
               end
            end else if (c_disable) begin
               if (i_disable_stop_select) begin
                  next_ramping = 1'b1;                        // [R15]
               end else begin
                  next_state = ST_SWITCHED_ON;                // [R14]
               end
            end
         end
         ST_QUICK_STOP: begin
            // only way out is through state 2, apart from a detected error taking it to state 7
            if (c_dis_volt || ramp_done) begin
               next_state = ST_SW_DISABLED;                   // [R16]
            end
         end
         ST_FAULT_REACT: begin
            if (i_fault_react_done) begin
               next_state = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (c_freset && !i_fault_detect) begin
               next_state = ST_SW_DISABLED;
            end
         end
         default: begin
            next_state = ST_FAULT_REACT;
         end
      endcase
      // detected error wins over any command
      if (i_fault_detect && !is_state(state, ST_NOT_READY) &&
          !is_state(state, ST_FAULT) &&
          !is_state(state, ST_FAULT_REACT)) begin
         next_state   = ST_FAULT_REACT;                       // [R3]
         next_ramping = 1'b0;
      end
   end

   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state   <= ST_NOT_READY;                             // [R18]
         ramping <= 1'b0;
      end else begin
         state   <= next_state;
         ramping <= next_ramping;
      end
   end

   // ==========================================================
   // outputs decoded from the state register; status word and valid from next_state
   wire in_s2 = is_state(state, ST_SW_DISABLED);
   wire in_s3 = is_state(state, ST_READY);
   wire in_s4 = is_state(state, ST_SWITCHED_ON);
   wire in_s5 = is_state(state, ST_OP_ENABLED);
   wire in_s6 = is_state(state, ST_QUICK_STOP);

   // refused changes simply get no accept
   assign o_cfg_accept = in_s2 || in_s3 || in_s4 ||
                         is_state(state, ST_FAULT);            // [R10]
   assign o_adj_accept = in_s2 || in_s3 || in_s4 || in_s5;    // [R4] [R8]

   // status word follows next_state so it moves on the state edge;
   // the enables follow the state register one cycle later, which
   // keeps them glitch free at the cost of one cycle of latency
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_state_status_word  <= {`DOSM_NUM_W{1'b0}};
         o_status_valid       <= 1'b0;
         o_power_stage_ready  <= 1'b0;
         o_power_stage_enable <= 1'b0;
         o_motor_supply       <= 1'b0;
         o_torque_enable      <= 1'b0;
         o_contactor_close    <= 1'b0;
         o_supply_required    <= 1'b0;
         o_ramp_stop          <= 1'b0;
         o_coast_stop         <= 1'b0;
         o_tune_start         <= 1'b0;
      end else begin
         case (next_state)                                    // [R19]
            ST_SW_DISABLED: o_state_status_word <= `DOSM_NUM_SW_DISABLED;
            ST_READY:       o_state_status_word <= `DOSM_NUM_READY;
            ST_SWITCHED_ON: o_state_status_word <= `DOSM_NUM_SWITCHED_ON;
            ST_OP_ENABLED:  o_state_status_word <= `DOSM_NUM_OP_ENABLED;
            ST_QUICK_STOP:  o_state_status_word <= `DOSM_NUM_QUICK_STOP;
            ST_FAULT_REACT: o_state_status_word <= `DOSM_NUM_FAULT_REACT;
            ST_FAULT:       o_state_status_word <= `DOSM_NUM_FAULT;
            default:        o_state_status_word <= {`DOSM_NUM_W{1'b0}};
         endcase
         // state 1 is hidden from the network
         o_status_valid <= !is_state(next_state, ST_NOT_READY); // [R1] [R2]
         o_power_stage_ready <= in_s3 || in_s4 || in_s5 || in_s6;  // [R4]
         o_power_stage_enable <= in_s5 || in_s6;             // [R10] [R17]
         o_motor_supply <= in_s5 || in_s6;                    // [R8] [R10]
         o_torque_enable <= (in_s5 && !ramping && !halt &&
                             !i_ref_zero) || in_s6 ||
                            (in_s5 && ramping);               // [R11]
         o_contactor_close <= i_contactor_variant &&
                              (in_s4 || in_s5 || in_s6);      // [R6]
         o_supply_required <= in_s4 || in_s5 || in_s6;        // [R7]
         o_ramp_stop <= (in_s5 && ramping) || in_s6;          // [R15]
         o_coast_stop <= in_s4;                               // [R14]
         o_tune_start <= in_s5 && !ramping && i_tune_req;     // [R12]
      end
   end

endmodule

// *** sim/dosm_top_assertions.sv ***
// Purpose: port-level assertions for the drive state sequencer
// Assumes: enables lag the status word by one cycle
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`include "dosm_map.vh"
module dosm_top_chk (
   input wire                   i_ref_clk,
   input wire                   i_arst_n,
   input wire [`DOSM_CMD_W-1:0] i_cmd,
   input wire                   i_cmd_valid,
   input wire                   i_disable_stop_select,
   input wire                   i_cfg_write,
   input wire                   i_fault_detect,
   input wire                   i_ramp_done,
   input wire [`DOSM_NUM_W-1:0] o_state_status_word,
   input wire                   o_status_valid,
   input wire                   o_power_stage_enable,
   input wire                   o_motor_supply,
   input wire                   o_torque_enable,
   input wire                   o_contactor_close,
   input wire                   o_supply_required,
   input wire                   o_ramp_stop,
   input wire                   o_tune_start,
   input wire                   o_cfg_accept
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   wire [3:0] st;
   wire       dis;
   assign st  = o_state_status_word;
   assign dis = i_cmd_valid && !i_fault_detect
                && i_cmd == `DOSM_CMD_DISABLE_OP;
   // ==========================================================
   // ramped stop: pin-level i_ramp_done must be quiet for 3 samples
   sequence s_ramp_cmd;
      st == 4'h5 && dis && i_disable_stop_select && !i_ramp_done
      && !$past(i_ramp_done) && !$past(i_ramp_done, 2);
   endsequence
   sequence s_ramp_hold;
      st == 4'h5 ##1 o_ramp_stop;
   endsequence
   // ==========================================================
   // assertions
   chk_init_shows: assert property ($rose(o_status_valid)
      |-> st == 4'h2) else $error("status not 2 after init");
   chk_state_hidden: assert property (o_status_valid == (st != 4'h0))
      else $error("status valid and state code disagree");
   chk_state_cause: assert property ($past(o_status_valid)
      && $past(st) inside {4'h2, 4'h3} && $changed(st)
      |-> $past(i_cmd_valid) || $past(i_fault_detect))
      else $error("state left without a cause");
   chk_contactor_open: assert property (o_contactor_close
      |-> $past(st) inside {4'h4, 4'h5, 4'h6})
      else $error("contactor closed outside states 4 to 6");
   chk_motor_locked: assert property (
      $past(st) inside {4'h2, 4'h3, 4'h4, 4'h8}
      |-> !o_motor_supply && !o_torque_enable && !o_power_stage_enable)
      else $error("motor supplied in a locked state");
   chk_supply_need: assert property ($past(st) inside {4'h4, 4'h5}
      |-> o_supply_required) else $error("supply not required");
   chk_run_enabled: assert property ($past(st) == 4'h5
      |-> o_power_stage_enable && o_motor_supply)
      else $error("state 5 without stage enable");
   chk_cfg_gate: assert property (
      o_cfg_accept == (st inside {4'h2, 4'h3, 4'h4, 4'h8}))
      else $error("configuration gate wrong");
   chk_cfg_fallback: assert property (st == 4'h4 && i_cfg_write
      && !i_cmd_valid && !i_fault_detect |=> st == 4'h2)
      else $error("no fall back after configuration write");
   chk_coast_now: assert property (st == 4'h5 && dis
      && !i_disable_stop_select |=> st == 4'h4)
      else $error("coast stop did not enter state 4");
   chk_ramp_first: assert property (s_ramp_cmd |=> s_ramp_hold)
      else $error("ramped stop left state 5 early");
   chk_tune_gate: assert property (o_tune_start
      |-> $past(st) == 4'h5) else $error("tuning outside state 5");
endmodule

bind dosm_top dosm_top_chk i_chk (.*);

// *** sim/dosm_master.sv ***
// Purpose: fieldbus master model for the state sequencer
// Assumes: one command pulse per call, idle cycle between
// Notes:   released command lines show the inverse code
`timescale 1ns/1ps
module dosm_master (
   input  wire       i_ref_clk,
   output reg  [2:0] o_cmd,
   output reg        o_cmd_valid,
   output reg        o_chan_ok,
   output reg        o_chan_ref,
   output reg        o_ref_seen
);
   initial begin
      o_cmd       = 3'h0;
      o_cmd_valid = 1'b0;
      {o_chan_ok, o_chan_ref, o_ref_seen} = 3'h7;
   end
   // channel flags: valid, carries reference, reference sent
   task chan(input [2:0] f);
      @(posedge i_ref_clk) {o_chan_ok, o_chan_ref, o_ref_seen} <= f;
   endtask
   task send(input [2:0] code);
      begin
         @(posedge i_ref_clk);
         o_cmd       <= code;
         o_cmd_valid <= 1'b1;
         @(posedge i_ref_clk);
         o_cmd_valid <= 1'b0;
         o_cmd       <= ~code;
      end
   endtask
endmodule

// *** sim/dosm_top_bench.sv ***
// Purpose: self-checking bench for the drive state sequencer
// Assumes: 50 MHz clock, commands come from the master model
// Notes:   all outputs are compared as one vector per state
`timescale 1ns/1ps
`include "dosm_map.vh"
module dosm_top_bench;
   reg         clk   = 1'b0;
   reg         rst_n = 1'b0;
   reg         sel   = 1'b0;
   reg         rz    = 1'b0;
   reg         cfg   = 1'b0;
   reg         adj   = 1'b0;
   reg         tune  = 1'b0;
   reg         flt   = 1'b0;
   reg         frd   = 1'b0;
   reg         mains = 1'b0;
   reg         halt  = 1'b0;
   reg         rdone = 1'b0;
   reg         vnt   = 1'b1;
   integer     failures = 0;
   integer     n_checks = 0;
   integer     k;
   wire [2:0]  cmd;
   wire        cv, chv, chr, rrx;
   wire [15:0] obs;
   always #10 clk = ~clk;
   dosm_master i_mst (.i_ref_clk(clk), .o_cmd(cmd), .o_cmd_valid(cv),
      .o_chan_ok(chv), .o_chan_ref(chr), .o_ref_seen(rrx));
   dosm_top i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_cmd(cmd),
      .i_cmd_valid(cv), .i_channel_valid(chv), .i_channel_has_ref(chr),
      .i_ref_received(rrx), .i_ref_zero(rz), .i_disable_stop_select(sel),
      .i_contactor_variant(vnt), .i_cfg_write(cfg), .i_adj_write(adj),
      .i_tune_req(tune), .i_fault_detect(flt), .i_fault_react_done(frd),
      .i_mains_ok(mains), .i_halt(halt), .i_ramp_done(rdone),
      .o_status_valid(obs[15]), .o_state_status_word(obs[14:11]),
      .o_power_stage_ready(obs[10]), .o_power_stage_enable(obs[9]),
      .o_motor_supply(obs[8]), .o_torque_enable(obs[7]),
      .o_contactor_close(obs[6]), .o_supply_required(obs[5]),
      .o_ramp_stop(obs[4]), .o_coast_stop(obs[3]), .o_tune_start(obs[2]),
      .o_cfg_accept(obs[1]), .o_adj_accept(obs[0]));
   // ==========================================================
   // expected outputs for state s; torque, ramp, tune given
   function [15:0] want(input [3:0] s, input t, input r, input u);
      want = {s != 4'h0, s, s >= 4'h3 && s <= 4'h6,
              s == 4'h5 || s == 4'h6, s == 4'h5 || s == 4'h6, t,
              vnt && s >= 4'h4 && s <= 4'h6, s >= 4'h4 && s <= 4'h6,
              r, s == 4'h4, u, s inside {4'h2, 4'h3, 4'h4, 4'h8},
              s >= 4'h2 && s <= 4'h5};
   endfunction
   task check(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value state outputs exp %h got %h", exp, got);
         end
      end
   endtask
   task see(input [3:0] s, input t, input r, input u);
      begin
         @(posedge clk);
         #1;
         check(obs, want(s, t, r, u));
      end
   endtask
   task go(input [2:0] c, input [3:0] s, input t, input r, input u);
      begin
         i_mst.send(c);
         see(s, t, r, u);
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task results;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      idle(20);
      rst_n <= 1'b1;
      see(4'h0, 0, 0, 0);
      k = 0;
      while (obs[15] !== 1'b1 && k < 60) begin
         @(posedge clk);
         #1;
         k = k + 1;
      end
      if (k == 60) begin
         failures = failures + 1;
         results;
      end
      see(4'h2, 0, 0, 0);
      go(`DOSM_CMD_SHUTDOWN, 4'h3, 0, 0, 0);
      go(`DOSM_CMD_SWITCH_ON, 4'h3, 0, 0, 0);
      @(posedge clk) mains <= 1'b1;
      idle(3);
      go(`DOSM_CMD_SWITCH_ON, 4'h4, 0, 0, 0);
      @(posedge clk) cfg <= 1'b1;
      @(posedge clk) cfg <= 1'b0;
      see(4'h2, 0, 0, 0);
      go(`DOSM_CMD_SHUTDOWN, 4'h3, 0, 0, 0);
      go(`DOSM_CMD_SWITCH_ON, 4'h4, 0, 0, 0);
      @(posedge clk) tune <= 1'b1;
      i_mst.chan(3'h0);
      go(`DOSM_CMD_ENABLE_OP, 4'h4, 0, 0, 0);
      i_mst.chan(3'h6);
      go(`DOSM_CMD_ENABLE_OP, 4'h4, 0, 0, 0);
      i_mst.chan(3'h4);
      go(`DOSM_CMD_ENABLE_OP, 4'h5, 1, 0, 1);
      @(posedge clk) halt <= 1'b1;
      tune <= 1'b0;
      idle(3);
      see(4'h5, 0, 0, 0);
      @(posedge clk) halt <= 1'b0;
      rz <= 1'b1;
      idle(3);
      see(4'h5, 0, 0, 0);
      @(posedge clk) rz <= 1'b0;
      go(`DOSM_CMD_DISABLE_OP, 4'h4, 0, 0, 0);
      go(`DOSM_CMD_ENABLE_OP, 4'h5, 1, 0, 0);
      @(posedge clk) sel <= 1'b1;
      go(`DOSM_CMD_DISABLE_OP, 4'h5, 1, 1, 0);
      @(posedge clk) rdone <= 1'b1;
      idle(4);
      see(4'h4, 0, 0, 0);
      @(posedge clk) rdone <= 1'b0;
      idle(4);
      go(`DOSM_CMD_ENABLE_OP, 4'h5, 1, 0, 0);
      go(`DOSM_CMD_QUICK_STOP, 4'h6, 1, 1, 0);
      go(`DOSM_CMD_ENABLE_OP, 4'h6, 1, 1, 0);
      go(`DOSM_CMD_DISABLE_V, 4'h2, 0, 0, 0);
      @(posedge clk) flt <= 1'b1;
      @(posedge clk);
      see(4'h7, 0, 0, 0);
      @(posedge clk) frd <= 1'b1;
      @(posedge clk);
      see(4'h8, 0, 0, 0);
      @(posedge clk) flt <= 1'b0;
      frd <= 1'b0;
      go(`DOSM_CMD_FAULT_RESET, 4'h2, 0, 0, 0);
      @(posedge clk) vnt <= 1'b0;
      go(`DOSM_CMD_SHUTDOWN, 4'h3, 0, 0, 0);
      go(`DOSM_CMD_SWITCH_ON, 4'h4, 0, 0, 0);
      results;
   end
endmodule
